/* File: logic/gti_bus_if.sv */
// open-drain two-wire link between target and controller
`timescale 1ns/1ps
`default_nettype none
interface gti_bus_if;
	logic scl_dev_o;
	logic scl_dev_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic scl_ext_low;
	logic sda_ext_low;
	logic scl;
	logic sda;

	// drivers only pull low; pull-up otherwise
	assign scl = !((scl_dev_oe && !scl_dev_o) ||
		(scl_host_oe && !scl_host_o) || scl_ext_low);
	assign sda = !((sda_dev_oe && !sda_dev_o) ||
		(sda_host_oe && !sda_host_o) || sda_ext_low);

	modport dev (
		input  scl,
		input  sda,
		output scl_dev_o,
		output scl_dev_oe,
		output sda_dev_o,
		output sda_dev_oe
	);
	modport host (
		input  scl,
		input  sda,
		output scl_host_o,
		output scl_host_oe,
		output sda_host_o,
		output sda_host_oe
	);
endinterface
`default_nettype wire

/* File: logic/gti_controller.sv */
// controller end: paced i2c master for the gauge target
`timescale 1ns/1ps
`default_nettype none
module gti_controller
	import gti_pkg::*;
#(
	parameter int unsigned BUF_CYC_P    = BUF_CYC,
	parameter int unsigned RESULT_CYC_P = RESULT_CYC,
	parameter int unsigned RATE_CYC_P   = RATE_CYC
)(
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	gti_bus_if.host         bus,
	input  wire logic       req_i,
	input  wire gti_op_type op_i,
	input  wire logic       use_cmd_i,
	input  wire logic [7:0] cmd_i,
	input  wire logic [3:0] len_i,
	input  wire logic [7:0] wdata_i,
	output logic            wtake_o,
	output logic [7:0]      rdata_o,
	output logic            rvalid_o,
	output logic            done_o,
	output logic            nack_o,
	output logic            busy_o
);
	typedef enum logic [2:0] {
		H_IDLE = 3'h0, H_GAP = 3'h1, H_START = 3'h3, H_BIT = 3'h2,
		H_STOP = 3'h6
	} gti_hstate_type;
	typedef enum logic [2:0] {
		S_ADDR_W = 3'h0, S_CMD = 3'h1, S_ADDR_R = 3'h3, S_WDATA = 3'h2,
		S_RDATA = 3'h6
	} gti_step_type;

	gti_hstate_type state_reg;
	gti_step_type   step_reg;
	gti_op_type     op_reg;
	logic [2:0]     sync_reg [2];
	logic [1:0]     line_reg;
	logic [7:0]     q_reg;
	logic [1:0]     ph_reg;
	logic [3:0]     bidx_reg;
	logic [3:0]     left_reg;
	logic [7:0]     tx_reg;
	logic [7:0]     rx_reg;
	logic           ack_reg;
	logic           cmd_reg;
	logic [7:0]     code_reg;
	logic           last_wr_reg;
	logic [31:0]    gap_reg;
	logic [31:0]    rate_reg;
	logic           scl_oe_reg;
	logic           sda_oe_reg;
	logic           wtake_reg;
	logic [7:0]     rdata_reg;
	logic           rvalid_reg;
	logic           done_reg;
	logic           nack_reg;
	logic           busy_reg;
	logic           adv;
	logic           gap_ok;

	// phase 1 waits for the target to let the clock rise
	assign adv = (q_reg == 8'(QTR_CYC - 1)); // R21 R19
	assign gap_ok = (gap_reg >= ((op_reg == OP_READ && last_wr_reg) ?
		RESULT_CYC_P : BUF_CYC_P)) && // R11 R14
		(!cmd_reg || rate_reg >= RATE_CYC_P); // R15

	assign bus.scl_host_o = 1'b0;
	assign bus.sda_host_o = 1'b0;
	assign bus.scl_host_oe = scl_oe_reg;
	assign bus.sda_host_oe = sda_oe_reg;
	assign wtake_o = wtake_reg;
	assign rdata_o = rdata_reg;
	assign rvalid_o = rvalid_reg;
	assign done_o = done_reg;
	assign nack_o = nack_reg;
	assign busy_o = busy_reg;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 2; i++) begin
				sync_reg[i] <= 3'h7;
			end
			line_reg <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				sync_reg[i] <= {sync_reg[i][1:0], (i == 0) ? bus.scl : bus.sda};
				if (sync_reg[i][1] == sync_reg[i][2]) begin
					line_reg[i] <= sync_reg[i][2];
				end
			end
		end
	end

	// time since last stop and since last command packet
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			gap_reg <= 32'hFFFF_FFFF;
			rate_reg <= 32'hFFFF_FFFF;
		end else begin
			if (done_reg) begin
				gap_reg <= 32'h0000_0000;
			end else if (gap_reg != 32'hFFFF_FFFF) begin
				gap_reg <= gap_reg + 32'h0000_0001;
			end
			if (done_reg && cmd_reg) begin
				rate_reg <= 32'h0000_0000;
			end else if (rate_reg != 32'hFFFF_FFFF) begin
				rate_reg <= rate_reg + 32'h0000_0001;
			end
		end
	end

	// line drive per state and phase
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			unique case (state_reg)
			H_START: begin
				scl_oe_reg <= ph_reg == 2'h0 || ph_reg == 2'h3;
				sda_oe_reg <= ph_reg[1];
			end
			H_BIT: begin
				scl_oe_reg <= ph_reg != 2'h1;
				sda_oe_reg <= (bidx_reg == 4'h8) ?
					(step_reg == S_RDATA && left_reg != 4'h1) :
					(step_reg != S_RDATA && !tx_reg[7]);
			end
			H_STOP: begin
				scl_oe_reg <= ph_reg == 2'h0;
				sda_oe_reg <= ph_reg != 2'h2;
			end
			default: begin
				scl_oe_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= H_IDLE;
			step_reg <= S_ADDR_W;
			op_reg <= OP_WRITE;
			q_reg <= 8'h00;
			ph_reg <= 2'h0;
			bidx_reg <= 4'h0;
			left_reg <= 4'h1;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			ack_reg <= 1'b0;
			cmd_reg <= 1'b0;
			code_reg <= 8'h00;
			last_wr_reg <= 1'b0;
			wtake_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			wtake_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			done_reg <= 1'b0;
			if (state_reg == H_IDLE || state_reg == H_GAP || adv ||
					(ph_reg == 2'h1 && !line_reg[0])) begin
				q_reg <= 8'h00;
			end else begin
				q_reg <= q_reg + 8'h01;
			end
			unique case (state_reg)
			H_IDLE: if (req_i) begin
				op_reg <= op_i;
				cmd_reg <= use_cmd_i;
				code_reg <= cmd_i;
				left_reg <= (len_i == 4'h0 || (op_i == OP_WRITE && FAST_BUS)) ?
					4'h1 : len_i; // R12 R13
				state_reg <= H_GAP;
				busy_reg <= 1'b1;
			end
			H_GAP: if (gap_ok) begin
				state_reg <= H_START;
				ph_reg <= 2'h0;
				step_reg <= (op_reg == OP_READ && !cmd_reg) ? S_ADDR_R : S_ADDR_W;
				tx_reg <= (op_reg == OP_READ && !cmd_reg) ? ADDR_RD : ADDR_WR;
			end
			H_START: if (adv) begin
				ph_reg <= ph_reg + 2'h1;
				if (ph_reg == 2'h3) begin
					state_reg <= H_BIT;
					bidx_reg <= 4'h0;
				end
			end
			H_BIT: if (adv) begin
				ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
				if (ph_reg == 2'h1) begin
					if (bidx_reg == 4'h8) begin
						ack_reg <= !line_reg[1];
					end else begin
						rx_reg <= {rx_reg[6:0], line_reg[1]};
					end
				end else if (ph_reg == 2'h2 && bidx_reg != 4'h8) begin
					bidx_reg <= bidx_reg + 4'h1;
					tx_reg <= {tx_reg[6:0], 1'b0};
				end else if (ph_reg == 2'h2) begin
					bidx_reg <= 4'h0;
					if (step_reg != S_RDATA && !ack_reg) begin
						nack_reg <= 1'b1; // R8
						state_reg <= H_STOP;
					end else begin
						unique case (step_reg)
						S_ADDR_W: begin
							step_reg <= S_CMD;
							tx_reg <= code_reg;
						end
						S_CMD: if (op_reg == OP_WRITE) begin
							step_reg <= S_WDATA;
							tx_reg <= wdata_i;
							wtake_reg <= 1'b1;
						end else begin
							step_reg <= S_ADDR_R;
							tx_reg <= ADDR_RD;
							state_reg <= H_START;
						end
						S_ADDR_R: step_reg <= S_RDATA;
						S_WDATA, S_RDATA: begin
							rvalid_reg <= step_reg == S_RDATA;
							rdata_reg <= rx_reg;
							left_reg <= left_reg - 4'h1;
							if (left_reg == 4'h1) begin
								state_reg <= H_STOP;
							end else if (step_reg == S_WDATA) begin
								tx_reg <= wdata_i;
								wtake_reg <= 1'b1;
							end
						end
						default: state_reg <= H_STOP;
						endcase
					end
				end
			end
			H_STOP: if (adv) begin
				ph_reg <= ph_reg + 2'h1;
				if (ph_reg == 2'h2) begin
					ph_reg <= 2'h0;
					state_reg <= H_IDLE;
					done_reg <= 1'b1;
					busy_reg <= 1'b0;
					last_wr_reg <= op_reg == OP_WRITE && cmd_reg;
				end
			end
			default: begin
				state_reg <= H_IDLE;
				busy_reg <= 1'b0;
			end
			endcase
			if (state_reg == H_IDLE && req_i) begin
				nack_reg <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: logic/gti_pkg.sv */
// shared constants and types for the gauge i2c target link
`default_nettype none
package gti_pkg;
	localparam logic [6:0] TGT_ADDR = 7'h55;
	localparam logic [7:0] ADDR_WR = {TGT_ADDR, 1'b0};
	localparam logic [7:0] ADDR_RD = {TGT_ADDR, 1'b1};
	localparam logic [7:0] CMD_LAST = 8'h6B;

	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned SCL_HZ = 400_000;
	localparam int unsigned SLOW_HZ = 100_000;
	localparam bit FAST_BUS = SCL_HZ > SLOW_HZ;
	localparam int unsigned QTR_CYC = CLK_HZ / (4 * SCL_HZ);

	localparam int unsigned TIMEOUT_S = 2;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
	localparam int unsigned SLACK_CYC = 8;
	localparam int unsigned WAKE_MS = 4;
	localparam int unsigned WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
	localparam int unsigned FLOW_MS = 4;
	localparam int unsigned FLOW_CYC = FLOW_MS * (CLK_HZ / 1000);
	localparam int unsigned BUF_US = 66;
	localparam int unsigned BUF_CYC =
		32'((longint'(BUF_US) * CLK_HZ + 999_999) / 1_000_000);
	localparam int unsigned RESULT_S = 2;
	localparam int unsigned RESULT_CYC = RESULT_S * CLK_HZ;
	localparam int unsigned RATE_MS = 500;
	localparam int unsigned RATE_CYC = RATE_MS * (CLK_HZ / 1000);

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_SLEEP  = 3'h1,
		MODE_DEEP   = 3'h2,
		MODE_PACK   = 3'h3,
		MODE_SNOOZE = 3'h4
	} gti_mode_type;

	typedef enum logic {
		OP_WRITE = 1'b0,
		OP_READ  = 1'b1
	} gti_op_type;
endpackage
`default_nettype wire

/* File: logic/gti_target.sv */
// device end: gauge i2c target engine with timeout and clock stretch
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - reads, incremental, quick read, writes accepted
// R2 - answer only address 1010101
// R3 - first byte AA write, AB read
// R4 - quick read starts at current pointer
// R5 - pointer steps on every acked data byte
// R6 - written bytes land at consecutive locations
// R7 - read-only location: nack, nothing stored
// R8 - command above 6B gets nack
// R9 - release both lines after 2 s low
// R10 - still low after release: enter sleep
// R11 - controller leaves 66 us free gap
// R12 - above 100 kHz only one-byte writes
// R13 - incremental write only at 100 kHz
// R14 - wait 2 s for read-write result
// R15 - at most two commands per second
// R16 - sleep modes: stretch every transaction, 4 ms
// R17 - awake modes: stretch own packets only
// R18 - flow control stretch up to 4 ms
// R19 - long stretches tolerated by controller
// R20 - low time per line, restart when high
// R21 - controller waits for clock release
module gti_target
	import gti_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC_P = TIMEOUT_CYC,
	parameter int unsigned WAKE_CYC_P    = WAKE_CYC,
	parameter int unsigned FLOW_CYC_P    = FLOW_CYC
)(
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	gti_bus_if.dev            bus,
	input  wire gti_mode_type mode_i,
	input  wire logic         busy_i,
	input  wire logic         ro_i,
	input  wire logic [7:0]   rd_data_i,
	output logic [7:0]        ptr_o,
	output logic              wr_o,
	output logic [7:0]        wr_data_o,
	output logic              sleep_o
);
	typedef enum logic [3:0] {
		T_IDLE      = 4'h0,
		T_ADDR      = 4'h1,
		T_ADDR_ACK  = 4'h3,
		T_CMD       = 4'h2,
		T_CMD_ACK   = 4'h6,
		T_WDATA     = 4'h7,
		T_WDATA_ACK = 4'h5,
		T_RDATA     = 4'h4,
		T_RDATA_ACK = 4'hC,
		T_WAIT      = 4'hD
	} gti_tstate_type;

	localparam logic [31:0] SLEEP_AT = 32'(TIMEOUT_CYC_P + SLACK_CYC);

	gti_tstate_type state_reg;
	logic [2:0]     sync_reg [2];
	logic [1:0]     line_reg;
	logic [1:0]     prev_reg;
	logic [31:0]    low_reg [2];
	logic [31:0]    wake_reg;
	logic [31:0]    flow_reg;
	logic           scl_oe_reg;
	logic           sda_oe_reg;
	logic           sleep_reg;
	logic [7:0]     sh_reg;
	logic [3:0]     bcnt_reg;
	logic [7:0]     ptr_reg;
	logic           wr_reg;
	logic           rw_reg;
	logic           scl;
	logic           sda;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_det;
	logic           stop_det;
	logic           tmo;
	logic           own;
	logic           want;

	assign scl = line_reg[0];
	assign sda = line_reg[1];
	assign scl_rise = scl && !prev_reg[0];
	assign scl_fall = !scl && prev_reg[0];
	assign start_det = scl && prev_reg[0] && prev_reg[1] && !sda;
	assign stop_det = scl && prev_reg[0] && !prev_reg[1] && sda;
	assign tmo = (low_reg[0] == TIMEOUT_CYC_P) ||
		(low_reg[1] == TIMEOUT_CYC_P);
	assign own = (state_reg != T_IDLE) && (state_reg != T_ADDR) &&
		(state_reg != T_WAIT);
	assign want = (wake_reg != 32'h0000_0000) ||
		(own && busy_i && (flow_reg < FLOW_CYC_P));

	assign bus.scl_dev_o = 1'b0;
	assign bus.sda_dev_o = 1'b0;
	assign bus.scl_dev_oe = scl_oe_reg;
	assign bus.sda_dev_oe = sda_oe_reg;
	assign ptr_o = ptr_reg;
	assign wr_o = wr_reg;
	assign wr_data_o = sh_reg;
	assign sleep_o = sleep_reg;

	// three-stage pin sync; a change counts once stages 2 and 3 agree
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 2; i++) begin
				sync_reg[i] <= 3'h7;
			end
			line_reg <= 2'h3;
			prev_reg <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				sync_reg[i] <= {sync_reg[i][1:0], (i == 0) ? bus.scl : bus.sda};
				if (sync_reg[i][1] == sync_reg[i][2]) begin
					line_reg[i] <= sync_reg[i][2];
				end
			end
			prev_reg <= line_reg;
		end
	end

	// low-time watch per line and sleep entry
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 2; i++) begin
				low_reg[i] <= 32'h0000_0000;
			end
			sleep_reg <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (line_reg[i]) begin
					low_reg[i] <= 32'h0000_0000; // R20
				end else if (low_reg[i] != SLEEP_AT) begin
					low_reg[i] <= low_reg[i] + 32'h0000_0001; // R20
				end
			end
			if (low_reg[0] == SLEEP_AT || low_reg[1] == SLEEP_AT) begin
				sleep_reg <= 1'b1; // R10
			end else if (line_reg == 2'h3) begin
				sleep_reg <= 1'b0;
			end
		end
	end

	// wake and flow-control stretch timers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_reg <= 32'h0000_0000;
			flow_reg <= 32'h0000_0000;
		end else begin
			if (tmo) begin
				wake_reg <= 32'h0000_0000;
			end else if (start_det && state_reg == T_IDLE &&
					(mode_i == MODE_SLEEP || mode_i == MODE_DEEP)) begin
				wake_reg <= WAKE_CYC_P; // R16
			end else if (wake_reg != 32'h0000_0000) begin
				wake_reg <= wake_reg - 32'h0000_0001;
			end
			if (scl) begin
				flow_reg <= 32'h0000_0000;
			end else if (scl_oe_reg && flow_reg < FLOW_CYC_P) begin
				flow_reg <= flow_reg + 32'h0000_0001; // R18
			end
		end
	end

	// clock stretch only once the line is already low
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_oe_reg <= 1'b0;
		end else if (tmo) begin
			scl_oe_reg <= 1'b0; // R9
		end else begin
			scl_oe_reg <= want && (scl_oe_reg || !scl); // R16 R17 R18
		end
	end

	// byte engine, acknowledge and pointer
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= T_IDLE;
			sh_reg <= 8'h00;
			bcnt_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
			ptr_reg <= 8'h00;
			wr_reg <= 1'b0;
			rw_reg <= 1'b0;
		end else begin
			wr_reg <= 1'b0;
			if (tmo || stop_det) begin
				state_reg <= T_IDLE;
				sda_oe_reg <= 1'b0; // R9
			end else if (start_det) begin
				state_reg <= T_ADDR;
				bcnt_reg <= 4'h0;
				sda_oe_reg <= 1'b0;
			end else begin
				unique case (state_reg)
				T_ADDR, T_CMD, T_WDATA: begin
					if (scl_rise && bcnt_reg != 4'h8) begin
						sh_reg <= {sh_reg[6:0], sda};
						bcnt_reg <= bcnt_reg + 4'h1;
					end else if (scl_fall && bcnt_reg == 4'h8) begin
						bcnt_reg <= 4'h0;
						state_reg <= T_WAIT;
						if (state_reg == T_ADDR) begin
							if (sh_reg == ADDR_WR || sh_reg == ADDR_RD) begin
								sda_oe_reg <= 1'b1; // R2 R3
								rw_reg <= sh_reg[0];
								state_reg <= T_ADDR_ACK;
							end
						end else if (state_reg == T_CMD) begin
							if (sh_reg <= CMD_LAST) begin
								sda_oe_reg <= 1'b1; // R8
								ptr_reg <= sh_reg;
								state_reg <= T_CMD_ACK;
							end
						end else if (!ro_i) begin
							sda_oe_reg <= 1'b1; // R7
							wr_reg <= 1'b1;
							state_reg <= T_WDATA_ACK;
						end
					end
				end
				T_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							sh_reg <= rd_data_i; // R4
							sda_oe_reg <= !rd_data_i[7];
							bcnt_reg <= 4'h1;
							state_reg <= T_RDATA;
						end else begin
							sda_oe_reg <= 1'b0;
							state_reg <= T_CMD;
						end
					end
				end
				T_CMD_ACK, T_WDATA_ACK: begin
					if (scl_fall) begin
						sda_oe_reg <= 1'b0;
						state_reg <= T_WDATA; // R1
						if (state_reg == T_WDATA_ACK) begin
							ptr_reg <= ptr_reg + 8'h01; // R5 R6
						end
					end
				end
				T_RDATA: begin
					if (scl_fall) begin
						if (bcnt_reg == 4'h8) begin
							sda_oe_reg <= 1'b0;
							state_reg <= T_RDATA_ACK;
						end else begin
							sda_oe_reg <= !sh_reg[6];
							sh_reg <= {sh_reg[6:0], 1'b0};
							bcnt_reg <= bcnt_reg + 4'h1;
						end
					end
				end
				T_RDATA_ACK: begin
					if (scl_rise) begin
						if (sda) begin
							state_reg <= T_WAIT;
						end else begin
							ptr_reg <= ptr_reg + 8'h01; // R5
							bcnt_reg <= 4'h0;
						end
					end
				end
				T_IDLE, T_WAIT: begin
				end
				default: begin
					state_reg <= T_IDLE;
				end
				endcase
				// next byte of an incremental read after controller ack
				if (state_reg == T_RDATA_ACK && scl_fall &&
						bcnt_reg == 4'h0) begin
					sh_reg <= rd_data_i; // R1
					sda_oe_reg <= !rd_data_i[7];
					bcnt_reg <= 4'h1;
					state_reg <= T_RDATA;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: verif/gauge_i2c_target_interface_tb.sv */
// bench: controller and target joined, transfers checked end to end
`timescale 1ns/1ps
`default_nettype none
module gauge_i2c_target_interface_tb;
	import gti_pkg::*;
	localparam int unsigned TO_P = 8000;
	localparam int unsigned WAKE_P = 300;
	localparam int unsigned FLOW_P = 300;
	localparam int unsigned BUF_P = 50;
	logic         mclk_i;
	logic         rst_i;
	gti_mode_type mode_i;
	logic         busy_i;
	logic         ro_i;
	logic [7:0]   rd_data_i;
	logic [7:0]   ptr_o;
	logic         wr_o;
	logic [7:0]   wr_data_o;
	logic         sleep_o;
	logic         req_i;
	gti_op_type   op_i;
	logic         use_cmd_i;
	logic [7:0]   cmd_i;
	logic [3:0]   len_i;
	logic [7:0]   wdata_i;
	logic         wtake_o;
	logic [7:0]   rdata_o;
	logic         rvalid_o;
	logic         done_o;
	logic         nack_o;
	logic         busy_o;
	int           mismatches;
	int           num_checks;
	int           busy_cnt;
	int           str_cnt;
	int           str0;
	logic [7:0]   rq[$];
	logic [15:0]  wq[$];

	gti_bus_if bus ();
	gti_target #(.TIMEOUT_CYC_P(TO_P), .WAKE_CYC_P(WAKE_P),
		.FLOW_CYC_P(FLOW_P)) u_gti_target (.mclk_i(mclk_i), .rst_i(rst_i),
		.bus(bus), .mode_i(mode_i), .busy_i(busy_i), .ro_i(ro_i),
		.rd_data_i(rd_data_i), .ptr_o(ptr_o), .wr_o(wr_o),
		.wr_data_o(wr_data_o), .sleep_o(sleep_o));
	gti_controller #(.BUF_CYC_P(BUF_P), .RESULT_CYC_P(100),
		.RATE_CYC_P(100)) u_gti_controller (.mclk_i(mclk_i), .rst_i(rst_i),
		.bus(bus), .req_i(req_i), .op_i(op_i), .use_cmd_i(use_cmd_i),
		.cmd_i(cmd_i), .len_i(len_i), .wdata_i(wdata_i), .wtake_o(wtake_o),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .done_o(done_o),
		.nack_o(nack_o), .busy_o(busy_o));
	gti_link_chk #(.TIMEOUT_CYC_P(TO_P), .WAKE_CYC_P(WAKE_P),
		.FLOW_CYC_P(FLOW_P), .BUF_CYC_P(BUF_P)) u_gti_link_chk (
		.mclk_i(mclk_i), .rst_i(rst_i), .scl(bus.scl), .sda(bus.sda),
		.scl_dev_oe(bus.scl_dev_oe), .sda_dev_oe(bus.sda_dev_oe),
		.scl_host_oe(bus.scl_host_oe), .sda_host_oe(bus.sda_host_oe));

	// memory model behind the pointer
	assign rd_data_i = ptr_o ^ 8'hC3;

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) begin
		if (rvalid_o === 1'b1)
			rq.push_back(rdata_o);
		if (wr_o === 1'b1)
			wq.push_back({ptr_o, wr_data_o});
		if (bus.scl_dev_oe === 1'b1)
			str_cnt++;
	end

	// brief flow-control stall after each byte taken
	always @(negedge mclk_i) begin
		if (wtake_o === 1'b1)
			busy_cnt = 200;
		busy_i <= busy_cnt != 0;
		if (busy_cnt != 0)
			busy_cnt--;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input gti_op_type op, input logic uc,
		input logic [7:0] cmd, input logic [3:0] n);
		int i;
		rq.delete();
		wq.delete();
		@(negedge mclk_i);
		op_i = op;
		use_cmd_i = uc;
		cmd_i = cmd;
		len_i = n;
		req_i = 1'b1;
		@(negedge mclk_i);
		req_i = 1'b0;
		chk(8'(busy_o), 8'h01);
		for (i = 0; i < 40000 && done_o !== 1'b1; i++)
			@(negedge mclk_i);
		if (i == 40000) begin
			mismatches++;
			$display("CHECK FAILED t=%0t transfer hung", $time);
			end_sim();
		end
	endtask

	initial begin
		rst_i = 1'b1;
		mode_i = MODE_NORMAL;
		ro_i = 1'b0;
		req_i = 1'b0;
		op_i = OP_WRITE;
		use_cmd_i = 1'b0;
		cmd_i = 8'h00;
		len_i = 4'h1;
		wdata_i = 8'h5A;
		bus.scl_ext_low = 1'b0;
		bus.sda_ext_low = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (20) @(negedge mclk_i);
		rst_i = 1'b0;
		chk(ptr_o, 8'h00);
		chk(8'(sleep_o), 8'h00);
		// one-byte write, stalled by flow control
		str0 = str_cnt;
		xfer(OP_WRITE, 1'b1, 8'h10, 4'h1);
		chk(8'(str_cnt != str0), 8'h01);
		chk(8'(busy_o), 8'h00);
		chk(8'(wq.size()), 8'h01);
		chk(wq[0][15:8], 8'h10);
		chk(wq[0][7:0], 8'h5A);
		chk(8'(nack_o), 8'h00);
		chk(ptr_o, 8'h11);
		// command read of two bytes
		str0 = str_cnt;
		xfer(OP_READ, 1'b1, 8'h20, 4'h2);
		chk(8'(str_cnt != str0), 8'h00);
		chk(8'(rq.size()), 8'h02);
		chk(rq[0], 8'h20 ^ 8'hC3);
		chk(rq[1], 8'h21 ^ 8'hC3);
		chk(ptr_o, 8'h21);
		// quick read while asleep: wake stretch
		mode_i = MODE_SLEEP;
		str0 = str_cnt;
		xfer(OP_READ, 1'b0, 8'h00, 4'h1);
		chk(8'(str_cnt != str0), 8'h01);
		chk(8'(rq.size()), 8'h01);
		chk(rq[0], 8'h21 ^ 8'hC3);
		chk(ptr_o, 8'h21);
		mode_i = MODE_NORMAL;
		// command just past the map
		xfer(OP_READ, 1'b1, 8'h6C, 4'h1);
		chk(8'(nack_o), 8'h01);
		chk(8'(rq.size()), 8'h00);
		// write to a read-only place
		ro_i = 1'b1;
		xfer(OP_WRITE, 1'b1, 8'h30, 4'h1);
		chk(8'(nack_o), 8'h01);
		chk(8'(wq.size()), 8'h00);
		ro_i = 1'b0;
		// outside party holds both lines low
		bus.scl_ext_low = 1'b1;
		repeat (10) @(negedge mclk_i);
		bus.sda_ext_low = 1'b1;
		repeat (TO_P + 40) @(negedge mclk_i);
		chk(8'(sleep_o), 8'h01);
		chk({6'h00, bus.scl_dev_oe, bus.sda_dev_oe}, 8'h00);
		bus.sda_ext_low = 1'b0;
		@(negedge mclk_i);
		bus.scl_ext_low = 1'b0;
		repeat (20) @(negedge mclk_i);
		chk(8'(sleep_o), 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire

/* File: verif/gti_link_chk.sv */
// link checker: timing relations on the two-wire bus between both ends
`timescale 1ns/1ps
`default_nettype none
module gti_link_chk
	import gti_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC_P = 8000,
	parameter int unsigned WAKE_CYC_P    = 300,
	parameter int unsigned FLOW_CYC_P    = 300,
	parameter int unsigned BUF_CYC_P     = 50
)(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic scl_dev_oe,
	input  wire logic sda_dev_oe,
	input  wire logic scl_host_oe,
	input  wire logic sda_host_oe
);
	localparam int unsigned STR_MAX =
		(WAKE_CYC_P > FLOW_CYC_P ? WAKE_CYC_P : FLOW_CYC_P) + 16;
	int unsigned scl_lo_reg;
	int unsigned sda_lo_reg;
	int unsigned scl_hi_reg;
	int unsigned str_reg;
	int unsigned idle_reg;
	logic        scl_q;
	logic        sda_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence start_s;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_s;
		scl && $past(scl) && $rose(sda);
	endsequence

	// continuous low time per line
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_lo_reg <= '0;
			sda_lo_reg <= '0;
		end else begin
			scl_lo_reg <= scl ? '0 : scl_lo_reg + 1;
			sda_lo_reg <= sda ? '0 : sda_lo_reg + 1;
		end
	end

	// clock high time and target stretch length
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			// released bus after reset counts as a full high phase
			scl_hi_reg <= QTR_CYC;
			str_reg <= '0;
		end else begin
			if (!scl)
				scl_hi_reg <= '0;
			else if (scl_hi_reg < QTR_CYC)
				scl_hi_reg <= scl_hi_reg + 1;
			str_reg <= scl_dev_oe ? str_reg + 1 : '0;
		end
	end

	// bus-free time since last stop
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_reg <= BUF_CYC_P;
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda && !sda_q)
				idle_reg <= '0;
			else if (idle_reg < BUF_CYC_P)
				idle_reg <= idle_reg + 1;
		end
	end

	dev_sda_launch_a: assert property (
		$rose(sda_dev_oe) |-> !scl)
		else $error("target began pulling data with clock high");
	dev_sda_hold_a: assert property (
		scl && $past(scl) && sda_lo_reg < TIMEOUT_CYC_P |-> $stable(sda_dev_oe))
		else $error("target data changed while clock high");
	stop_quiet_a: assert property (
		stop_s |=> (!sda_dev_oe) [*8])
		else $error("target pulled data right after stop");
	host_start_a: assert property (
		start_s |-> sda_host_oe && !sda_dev_oe)
		else $error("start not made by controller");
	bus_gap_a: assert property (
		start_s |-> idle_reg >= BUF_CYC_P)
		else $error("bus-free gap too short");
	stretch_bound_a: assert property (
		str_reg <= STR_MAX)
		else $error("target clock stretch too long");
	host_clk_wait_a: assert property (
		$rose(scl_host_oe) |-> $past(scl_hi_reg) >= QTR_CYC)
		else $error("controller pulled clock before full high phase");
	scl_free_a: assert property (
		scl_lo_reg >= TIMEOUT_CYC_P + 8 |-> !scl_dev_oe && !sda_dev_oe)
		else $error("target kept lines after clock low timeout");
	sda_free_a: assert property (
		sda_lo_reg >= TIMEOUT_CYC_P + 8 |-> !scl_dev_oe && !sda_dev_oe)
		else $error("target kept lines after data low timeout");
endmodule
`default_nettype wire
